// ### logic/gpe_map.vh
`ifndef GPE_MAP_VH
`define GPE_MAP_VH
// register indices on the plain register port
`define GPE_A_W             4
`define GPE_OFF_J_DATA      4'h0
`define GPE_OFF_J_DIR       4'h1
`define GPE_OFF_J_DRIVE     4'h2
`define GPE_OFF_J_PULL      4'h3
`define GPE_OFF_J_POL       4'h4
`define GPE_OFF_J_IRQ_EN    4'h5
`define GPE_OFF_J_FLAGS     4'h6
`define GPE_OFF_J_INPUT     4'h7
`define GPE_OFF_AD_HI_DATA  4'h8
`define GPE_OFF_AD_LO_DATA  4'h9
`define GPE_OFF_AD_HI_DIR   4'ha
`define GPE_OFF_AD_LO_DIR   4'hb
`define GPE_OFF_AD_ALT_HI   4'hc
`define GPE_OFF_AD_ALT_LO   4'hd
// printed address of the low analog data register
`define GPE_ADDR_AD_LO      16'h0271
// implemented bits of port j: 7-6 and 2-0
`define GPE_J_MASK          8'hc7
`define GPE_AD_HI_MASK      8'h03
`define GPE_RST_BYTE        8'h00
`define GPE_ZERO_BYTE       8'h00
`define GPE_RST_AD          10'h000
`define GPE_RST_BIT         1'b0
`endif

// ### logic/gpe_port.v
`timescale 1ns/1ps
// Summary of operation
// - each implemented port j direction bit makes its pin an output at 1 and an input at 0.
// - each drive select bit chooses reduced drive at 1 and full drive at 0 on its own output.
// - reduced drive applies whatever function owns the pin and does nothing on an input.
// - a pull enable bit turns on the pull device only while its pin is an input.
// - polarity 1 means pull-down and rising edge, polarity 0 pull-up and falling edge.
// - interrupt enable 1 lets a flag raise the interrupt, 0 masks it but the flag still sets.
// - a flag sets when an edge of the chosen polarity appears on the pin input.
// - writing 1 to a flag bit clears it, bits written 0 stay as they are.
// - the interrupt request is high while any pin has both flag and enable set.
// - reading the analog port data gives the stored bit for outputs, else the pin state.
// - an analog-shared pin not claimed by the converter and set as output drives its data bit.
// - the low analog data register resets to zero and bit n is also analog input n.
// - edge detection works on port j pins whether they are inputs or outputs.
`include "gpe_map.vh"

module gpe_port (
    SYS_CLK,
    SYS_RST,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    J_PIN_IN,
    J_PIN_OUT,
    J_PIN_OE_N,
    J_REDUCED_DRIVE,
    J_PULL_EN,
    J_PULL_DOWN,
    AD_PIN_IN,
    AD_PIN_OUT,
    AD_PIN_OE_N,
    AD_ANALOG_IN,
    IRQ
);
    input                    SYS_CLK;
    input                    SYS_RST;
    input  [`GPE_A_W-1:0]    ADDR;
    input  [7:0]             WDATA;
    input                    WR;
    input                    RD;
    output [7:0]             RDATA;
    input  [7:0]             J_PIN_IN;
    output [7:0]             J_PIN_OUT;
    output [7:0]             J_PIN_OE_N;
    output [7:0]             J_REDUCED_DRIVE;
    output [7:0]             J_PULL_EN;
    output [7:0]             J_PULL_DOWN;
    input  [9:0]             AD_PIN_IN;
    output [9:0]             AD_PIN_OUT;
    output [9:0]             AD_PIN_OE_N;
    output [7:0]             AD_ANALOG_IN;
    output                   IRQ;

    reg  [7:0]  j_data_ff;
    reg  [7:0]  j_dir_ff;
    reg  [7:0]  j_drive_ff;
    reg  [7:0]  j_pull_ff;
    reg  [7:0]  j_pol_ff;
    reg  [7:0]  j_irq_en_ff;
    reg  [7:0]  j_flags_ff;
    reg  [7:0]  j_sync1_ff;
    reg  [7:0]  j_sync2_ff;
    reg  [7:0]  j_last_ff;
    reg  [7:0]  ad_hi_data_ff;
    reg  [7:0]  ad_lo_data_ff;
    reg  [7:0]  ad_hi_dir_ff;
    reg  [7:0]  ad_lo_dir_ff;
    reg  [7:0]  ad_alt_hi_ff;
    reg  [7:0]  ad_alt_lo_ff;
    reg  [9:0]  ad_sync1_ff;
    reg  [9:0]  ad_sync2_ff;
    reg  [7:0]  rdata_ff;
    reg         irq_ff;
    reg  [7:0]  nxt_rdata;
    reg  [7:0]  nxt_flags;
    wire [7:0]  edge_hit;
    wire [7:0]  w1c;
    reg  [7:0]  nxt_j_data;
    reg  [7:0]  nxt_j_dir;
    reg  [7:0]  nxt_j_drive;
    reg  [7:0]  nxt_j_pull;
    reg  [7:0]  nxt_j_pol;
    reg  [7:0]  nxt_j_irq_en;
    reg  [7:0]  nxt_ad_hi_data;
    reg  [7:0]  nxt_ad_lo_data;
    reg  [7:0]  nxt_ad_hi_dir;
    reg  [7:0]  nxt_ad_lo_dir;
    reg  [7:0]  nxt_ad_alt_hi;
    reg  [7:0]  nxt_ad_alt_lo;
    reg         nxt_irq;
    wire        wr_j_data;
    wire        wr_j_dir;
    wire        wr_j_drive;
    wire        wr_j_pull;
    wire        wr_j_pol;
    wire        wr_j_irq_en;
    wire        wr_ad_hi_data;
    wire        wr_ad_lo_data;
    wire        wr_ad_hi_dir;
    wire        wr_ad_lo_dir;
    wire        wr_ad_alt_hi;
    wire        wr_ad_alt_lo;

    // source of a data read: stored bit for outputs, pin otherwise
    function [7:0] mux_read;
        input [7:0] dir;
        input [7:0] stored;
        input [7:0] pin;
        begin
            mux_read = (dir & stored) | (~dir & pin);
        end
    endfunction

    // write strobe decode for one register index
    function wr_hit;
        input                wr;
        input [`GPE_A_W-1:0] addr;
        input [`GPE_A_W-1:0] index;
        begin
            wr_hit = wr && (addr == index);
        end
    endfunction

    // unmapped indices decode to no strobe, so their writes fall away
    assign wr_j_data     = wr_hit(WR, ADDR, `GPE_OFF_J_DATA);
    assign wr_j_dir      = wr_hit(WR, ADDR, `GPE_OFF_J_DIR);
    assign wr_j_drive    = wr_hit(WR, ADDR, `GPE_OFF_J_DRIVE);
    assign wr_j_pull     = wr_hit(WR, ADDR, `GPE_OFF_J_PULL);
    assign wr_j_pol      = wr_hit(WR, ADDR, `GPE_OFF_J_POL);
    assign wr_j_irq_en   = wr_hit(WR, ADDR, `GPE_OFF_J_IRQ_EN);
    assign wr_ad_hi_data = wr_hit(WR, ADDR, `GPE_OFF_AD_HI_DATA);
    assign wr_ad_lo_data = wr_hit(WR, ADDR, `GPE_OFF_AD_LO_DATA);
    assign wr_ad_hi_dir  = wr_hit(WR, ADDR, `GPE_OFF_AD_HI_DIR);
    assign wr_ad_lo_dir  = wr_hit(WR, ADDR, `GPE_OFF_AD_LO_DIR);
    assign wr_ad_alt_hi  = wr_hit(WR, ADDR, `GPE_OFF_AD_ALT_HI);
    assign wr_ad_alt_lo  = wr_hit(WR, ADDR, `GPE_OFF_AD_ALT_LO);

    // edges compare the two synchronised stages only, never the raw first stage
    assign edge_hit = `GPE_J_MASK &
                      ((j_pol_ff & j_sync2_ff & ~j_last_ff) |
                       (~j_pol_ff & ~j_sync2_ff & j_last_ff));
    assign w1c = (WR && ADDR == `GPE_OFF_J_FLAGS) ? WDATA : `GPE_ZERO_BYTE;

    always @* begin
        // set beats a clear that lands in the same cycle
        nxt_flags = ((j_flags_ff & ~w1c) | edge_hit) & `GPE_J_MASK;
    end

    always @* begin
        case (ADDR)
            `GPE_OFF_J_DATA:     nxt_rdata = mux_read(j_dir_ff, j_data_ff, j_sync2_ff) &
                                             `GPE_J_MASK;
            `GPE_OFF_J_DIR:      nxt_rdata = j_dir_ff;
            `GPE_OFF_J_DRIVE:    nxt_rdata = j_drive_ff;
            `GPE_OFF_J_PULL:     nxt_rdata = j_pull_ff;
            `GPE_OFF_J_POL:      nxt_rdata = j_pol_ff;
            `GPE_OFF_J_IRQ_EN:   nxt_rdata = j_irq_en_ff;
            `GPE_OFF_J_FLAGS:    nxt_rdata = j_flags_ff;
            `GPE_OFF_J_INPUT:    nxt_rdata = j_sync2_ff & `GPE_J_MASK;
            `GPE_OFF_AD_HI_DATA: nxt_rdata = mux_read(ad_hi_dir_ff, ad_hi_data_ff,
                                                      {6'h00, ad_sync2_ff[9:8]});
            `GPE_OFF_AD_LO_DATA: nxt_rdata = mux_read(ad_lo_dir_ff, ad_lo_data_ff,
                                                      ad_sync2_ff[7:0]);
            `GPE_OFF_AD_HI_DIR:  nxt_rdata = ad_hi_dir_ff;
            `GPE_OFF_AD_LO_DIR:  nxt_rdata = ad_lo_dir_ff;
            `GPE_OFF_AD_ALT_HI:  nxt_rdata = ad_alt_hi_ff;
            `GPE_OFF_AD_ALT_LO:  nxt_rdata = ad_alt_lo_ff;
            default:             nxt_rdata = `GPE_ZERO_BYTE;
        endcase
    end

    always @* begin
        // new enable counts at once, so a masked flag never leaks for a cycle
        nxt_irq = |(nxt_flags & nxt_j_irq_en);
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            j_flags_ff <= `GPE_RST_BYTE;
            rdata_ff   <= `GPE_RST_BYTE;
            irq_ff     <= `GPE_RST_BIT;
        end else begin
            j_flags_ff <= nxt_flags;
            irq_ff     <= nxt_irq;
            if (RD)
                rdata_ff <= nxt_rdata;
        end
    end

    // one next-value process and one flop per register keeps each write rule local
    always @* begin
        nxt_j_data = j_data_ff;
        if (wr_j_data)
            nxt_j_data = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_data_ff <= `GPE_RST_BYTE;
        else
            j_data_ff <= nxt_j_data;
    end

    always @* begin
        nxt_j_dir = j_dir_ff;
        if (wr_j_dir)
            nxt_j_dir = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_dir_ff <= `GPE_RST_BYTE;
        else
            j_dir_ff <= nxt_j_dir;
    end

    always @* begin
        nxt_j_drive = j_drive_ff;
        if (wr_j_drive)
            nxt_j_drive = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_drive_ff <= `GPE_RST_BYTE;
        else
            j_drive_ff <= nxt_j_drive;
    end

    always @* begin
        nxt_j_pull = j_pull_ff;
        if (wr_j_pull)
            nxt_j_pull = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_pull_ff <= `GPE_RST_BYTE;
        else
            j_pull_ff <= nxt_j_pull;
    end

    always @* begin
        nxt_j_pol = j_pol_ff;
        if (wr_j_pol)
            nxt_j_pol = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_pol_ff <= `GPE_RST_BYTE;
        else
            j_pol_ff <= nxt_j_pol;
    end

    always @* begin
        nxt_j_irq_en = j_irq_en_ff;
        if (wr_j_irq_en)
            nxt_j_irq_en = WDATA & `GPE_J_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            j_irq_en_ff <= `GPE_RST_BYTE;
        else
            j_irq_en_ff <= nxt_j_irq_en;
    end

    always @* begin
        nxt_ad_hi_data = ad_hi_data_ff;
        if (wr_ad_hi_data)
            nxt_ad_hi_data = WDATA & `GPE_AD_HI_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_hi_data_ff <= `GPE_RST_BYTE;
        else
            ad_hi_data_ff <= nxt_ad_hi_data;
    end

    always @* begin
        nxt_ad_lo_data = ad_lo_data_ff;
        if (wr_ad_lo_data)
            nxt_ad_lo_data = WDATA;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_lo_data_ff <= `GPE_RST_BYTE;
        else
            ad_lo_data_ff <= nxt_ad_lo_data;
    end

    always @* begin
        nxt_ad_hi_dir = ad_hi_dir_ff;
        if (wr_ad_hi_dir)
            nxt_ad_hi_dir = WDATA & `GPE_AD_HI_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_hi_dir_ff <= `GPE_RST_BYTE;
        else
            ad_hi_dir_ff <= nxt_ad_hi_dir;
    end

    always @* begin
        nxt_ad_lo_dir = ad_lo_dir_ff;
        if (wr_ad_lo_dir)
            nxt_ad_lo_dir = WDATA;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_lo_dir_ff <= `GPE_RST_BYTE;
        else
            ad_lo_dir_ff <= nxt_ad_lo_dir;
    end

    always @* begin
        nxt_ad_alt_hi = ad_alt_hi_ff;
        if (wr_ad_alt_hi)
            nxt_ad_alt_hi = WDATA & `GPE_AD_HI_MASK;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_alt_hi_ff <= `GPE_RST_BYTE;
        else
            ad_alt_hi_ff <= nxt_ad_alt_hi;
    end

    always @* begin
        nxt_ad_alt_lo = ad_alt_lo_ff;
        if (wr_ad_alt_lo)
            nxt_ad_alt_lo = WDATA;
    end

    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            ad_alt_lo_ff <= `GPE_RST_BYTE;
        else
            ad_alt_lo_ff <= nxt_ad_alt_lo;
    end

    // synchronisers; last stage feeds edge detection and reads
    always @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            j_sync1_ff  <= `GPE_RST_BYTE;
            j_sync2_ff  <= `GPE_RST_BYTE;
            j_last_ff   <= `GPE_RST_BYTE;
            ad_sync1_ff <= `GPE_RST_AD;
            ad_sync2_ff <= `GPE_RST_AD;
        end else begin
            j_sync1_ff  <= J_PIN_IN;
            j_sync2_ff  <= j_sync1_ff;
            j_last_ff   <= j_sync2_ff;
            ad_sync1_ff <= AD_PIN_IN;
            ad_sync2_ff <= ad_sync1_ff;
        end
    end

    assign RDATA           = rdata_ff;
    assign IRQ             = irq_ff;
    assign J_PIN_OUT       = j_data_ff;
    assign J_PIN_OE_N      = ~j_dir_ff;
    // reduced drive only matters on outputs, no matter who owns the pin
    assign J_REDUCED_DRIVE = j_drive_ff & j_dir_ff;
    assign J_PULL_EN       = j_pull_ff & ~j_dir_ff;
    assign J_PULL_DOWN     = j_pol_ff;
    assign AD_PIN_OUT      = {ad_hi_data_ff[1:0], ad_lo_data_ff};
    assign AD_PIN_OE_N     = ~({ad_hi_dir_ff[1:0], ad_lo_dir_ff} &
                               ~{ad_alt_hi_ff[1:0], ad_alt_lo_ff});
    assign AD_ANALOG_IN    = ad_lo_data_ff;

endmodule // gpe_port

// ### tb/gpe_chk.sv
`timescale 1ns/1ps
module gpe_chk (
    input wire logic       SYS_CLK,
    input wire logic       SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] J_PIN_IN,
    input wire logic [7:0] J_PIN_OE_N,
    input wire logic [7:0] J_REDUCED_DRIVE,
    input wire logic [7:0] J_PULL_EN,
    input wire logic [7:0] J_PULL_DOWN,
    input wire logic [7:0] AD_ANALOG_IN,
    input wire logic       IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic [7:0] j_last_ff;
    logic [2:0] calm_ff;
    // calm counts quiet pin cycles so in-flight synchroniser edges are excluded
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            j_last_ff <= 8'h00;
            calm_ff   <= 3'h0;
        end else begin
            j_last_ff <= J_PIN_IN;
            calm_ff   <= (J_PIN_IN != j_last_ff) ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
        end
    end
    a_dir_to_oe: assert property (WR && ADDR == 4'h1 |=>
        (J_PIN_OE_N & 8'hc7) == (~$past(WDATA) & 8'hc7)) else $error("direction not applied");
    a_drive_sel_wr: assert property (WR && ADDR == 4'h2 |=>
        (J_REDUCED_DRIVE & 8'hc7) == ($past(WDATA) & ~J_PIN_OE_N & 8'hc7)) else $error("drive bad");
    a_drive_input_off: assert property ((J_REDUCED_DRIVE & J_PIN_OE_N) == 8'h00)
        else $error("reduced drive on input");
    a_pull_output_off: assert property ((J_PULL_EN & ~J_PIN_OE_N) == 8'h00)
        else $error("pull on output");
    a_polarity_wr: assert property (WR && ADDR == 4'h4 |=>
        (J_PULL_DOWN & 8'hc7) == ($past(WDATA) & 8'hc7)) else $error("polarity bad");
    a_quiet_no_irq: assert property (!IRQ && !WR && calm_ff == 3'h7 |=> !IRQ)
        else $error("irq without edge");
    a_clear_all_irq: assert property (WR && ADDR == 4'h6 && WDATA == 8'hff && calm_ff == 3'h7
        |=> !IRQ) else $error("irq after clear");
    a_pin_read_mask: assert property (RD && ADDR == 4'h7 && calm_ff == 3'h7
        |=> RDATA == ($past(J_PIN_IN) & 8'hc7)) else $error("pin read bad");
    a_unmapped_zero: assert property (RD && ADDR >= 4'he |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_analog_follow: assert property (WR && ADDR == 4'h9 |=> AD_ANALOG_IN == $past(WDATA))
        else $error("analog input bad");
    c_irq_rise: cover property ($rose(IRQ));
    c_flag_clear: cover property (WR && ADDR == 4'h6);
    c_pin_read: cover property (RD && ADDR == 4'h7 && calm_ff == 3'h7);
endmodule // gpe_chk

bind gpe_port gpe_chk i_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .J_PIN_IN(J_PIN_IN), .J_PIN_OE_N(J_PIN_OE_N),
    .J_REDUCED_DRIVE(J_REDUCED_DRIVE), .J_PULL_EN(J_PULL_EN), .J_PULL_DOWN(J_PULL_DOWN),
    .AD_ANALOG_IN(AD_ANALOG_IN), .IRQ(IRQ));

// ### tb/gpe_pins.sv
`timescale 1ns/1ps
module gpe_pins (
    input wire logic       clk,
    input wire logic [7:0] j_out,
    input wire logic [7:0] j_oe_n,
    input wire logic [7:0] j_pull_en,
    input wire logic [7:0] j_pull_down,
    input wire logic [9:0] ad_out,
    input wire logic [9:0] ad_oe_n,
    input wire logic [7:0] ext_j_en,
    input wire logic [7:0] ext_j_val,
    input wire logic [9:0] ext_ad_val,
    output logic     [7:0] j_in,
    output logic     [9:0] ad_in
);
    logic tog_ff = 1'b0;
    // a floating pin wanders, so undriven unpulled port j pins toggle every cycle
    always @(posedge clk) tog_ff <= ~tog_ff;
    assign j_in = (~j_oe_n & j_out) | (j_oe_n & ext_j_en & ext_j_val)
        | (j_oe_n & ~ext_j_en & ((j_pull_en & ~j_pull_down) | (~j_pull_en & {8{tog_ff}})));
    assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & ext_ad_val);
endmodule // gpe_pins

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk = 0, rst = 1, wr = 0, rd = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, ej_en = 8'hff, ej_val = 0, rdata, j_out, j_oe_n, j_rd, j_pe, j_pd;
    logic [7:0] j_in, ad_ai;
    logic [9:0] ead_val = 10'h2a5, ad_out, ad_oe_n, ad_in;
    logic       irq;
    int         num_errors = 0, check_count = 0, cyc = 0;
    initial forever #4 clk = ~clk;
    gpe_port i_dut (.SYS_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .J_PIN_IN(j_in), .J_PIN_OUT(j_out), .J_PIN_OE_N(j_oe_n),
        .J_REDUCED_DRIVE(j_rd), .J_PULL_EN(j_pe), .J_PULL_DOWN(j_pd), .AD_PIN_IN(ad_in),
        .AD_PIN_OUT(ad_out), .AD_PIN_OE_N(ad_oe_n), .AD_ANALOG_IN(ad_ai), .IRQ(irq));
    gpe_pins i_pins (.clk(clk), .j_out(j_out), .j_oe_n(j_oe_n), .j_pull_en(j_pe),
        .j_pull_down(j_pd), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ext_j_en(ej_en),
        .ext_j_val(ej_val), .ext_ad_val(ead_val), .j_in(j_in), .ad_in(ad_in));
    task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1;
        @(posedge clk); wr <= 0; #1;
    endtask
    task rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk); addr <= a; rd <= 1;
        @(posedge clk); rd <= 0; #1;
        chk("rdata", {2'h0, e}, {2'h0, rdata});
    endtask
    // synchroniser plus flag stage needs three cycles, one spare
    task pins(input logic [7:0] v);
        @(posedge clk); ej_val <= v;
        repeat (4) @(posedge clk);
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0; #1;
        chk("oe_n", 10'h0ff, {2'h0, j_oe_n});
        chk("irq", 10'h0, {9'h0, irq});
        for (int a = 1; a < 7; a++) rd_reg(a[3:0], 8'h00);
        rd_reg(4'h9, 8'ha5);
        chk("analog", 10'h0, {2'h0, ad_ai});
        for (int a = 1; a < 6; a++) begin
            wr_reg(a[3:0], 8'hff);
            rd_reg(a[3:0], 8'hc7);
        end
        chk("oe_n", 10'h038, {2'h0, j_oe_n});
        chk("drive", 10'h0c7, {2'h0, j_rd});
        chk("pull", 10'h0, {2'h0, j_pe});
        chk("pull_down", 10'h0c7, {2'h0, j_pd});
        wr_reg(4'h1, 8'h00);
        chk("drive", 10'h0, {2'h0, j_rd});
        chk("pull", 10'h0c7, {2'h0, j_pe});
        wr_reg(4'h4, 8'h01);
        wr_reg(4'h5, 8'h00);
        pins(8'h02);
        pins(8'h01);
        rd_reg(4'h6, 8'h03);
        chk("irq", 10'h0, {9'h0, irq});
        wr_reg(4'h5, 8'h01);
        rd_reg(4'h6, 8'h03);
        chk("irq", 10'h1, {9'h0, irq});
        wr_reg(4'h6, 8'h02);
        rd_reg(4'h6, 8'h01);
        chk("irq", 10'h1, {9'h0, irq});
        wr_reg(4'h6, 8'h01);
        rd_reg(4'h6, 8'h00);
        chk("irq", 10'h0, {9'h0, irq});
        pins(8'h00);
        rd_reg(4'h6, 8'h00);
        wr_reg(4'h4, 8'h41);
        wr_reg(4'h1, 8'h40);
        wr_reg(4'h0, 8'h40);
        chk("j_out", 10'h040, {2'h0, j_out});
        repeat (4) @(posedge clk);
        rd_reg(4'h6, 8'h40);
        rd_reg(4'h0, 8'h40);
        chk("irq", 10'h0, {9'h0, irq});
        wr_reg(4'h6, 8'hff);
        repeat (8) @(posedge clk);
        rd_reg(4'h7, 8'h40);
        pins(8'h38);
        rd_reg(4'h0, 8'h40);
        rd_reg(4'h7, 8'h40);
        rd_reg(4'h6, 8'h00);
        wr_reg(4'hb, 8'hff);
        wr_reg(4'h9, 8'h5a);
        rd_reg(4'h9, 8'h5a);
        chk("ad_oe_n", 10'h300, ad_oe_n);
        chk("ad_out", 10'h05a, ad_out);
        chk("analog", 10'h05a, {2'h0, ad_ai});
        wr_reg(4'hd, 8'hff);
        wr_reg(4'ha, 8'hff);
        wr_reg(4'h8, 8'hff);
        rd_reg(4'h8, 8'h03);
        chk("ad_oe_n", 10'h0ff, ad_oe_n);
        chk("ad_out", 10'h35a, ad_out);
        wr_reg(4'he, 8'hff);
        rd_reg(4'he, 8'h00);
        rd_reg(4'hf, 8'h00);
        test_done;
    end
endmodule // tb
